// ---- dmc_pkg.sv ----
// package of constants and types for the dynamic memory host controller
// Function
// - early write: write low before column strobe
// - delayed write latches data on write fall
// - output enable high before driving data
// - refresh all 512 rows every 8 ms
// - row-only refresh: column strobe high, external row
// - hidden refresh: column low, row strobe cycles
// - column-before-row refresh uses internal counter
// - back-to-back refresh with column held low; the controller raises the column strobe between refreshes
// - wait 200 us then eight init cycles
// - write strobe high reads, low writes
// - nine row then nine column bits
package dmc_pkg;
  // =====================================================================
  // geometry
  localparam int ADDR_W = 9;        // multiplexed address pins
  localparam int DATA_W = 4;        // data lines
  // =====================================================================
  // timing in ns / us and the derived cycle counts at 40 MHz
  localparam int CLK_NS = 25;
  localparam int T_RP_NS = 80;      // row precharge
  localparam int T_RAS_NS = 100;    // row strobe low
  localparam int T_RCD_NS = 30;     // row to column strobe
  localparam int T_CAS_NS = 25;     // column strobe low
  localparam int T_CAC_NS = 25;     // column access time
  localparam int T_CAA_NS = 45;     // column address access time
  localparam int T_OFF_NS = 35;     // output disable
  localparam int T_CSR_NS = 10;     // column before row setup
  localparam int T_CHR_NS = 25;     // column hold after row in refresh
  localparam int T_INIT_US = 200;   // power-up pause
  localparam int T_REFI_NS = 15600; // refresh interval
  localparam int INIT_CYCLES = 8;   // wake-up cycles
  function automatic int cyc_min(input int ns);
    cyc_min = (ns + CLK_NS - 1) / CLK_NS < 1 ? 1 : (ns + CLK_NS - 1) / CLK_NS;
  endfunction : cyc_min
  localparam int C_RP = cyc_min(T_RP_NS);
  localparam int C_RCD = cyc_min(T_RCD_NS);
  localparam int C_RAS = cyc_min(T_RAS_NS);
  // read sample waits for the later of column access and address access, plus sync
  localparam int C_CAC = cyc_min(T_CAA_NS > T_CAC_NS ? T_CAA_NS : T_CAC_NS);
  localparam int C_CAS = cyc_min(T_CAS_NS);
  localparam int C_OFF = cyc_min(T_OFF_NS);
  localparam int C_CSR = cyc_min(T_CSR_NS);
  localparam int C_CHR = cyc_min(T_CHR_NS);
  localparam int C_INIT = T_INIT_US * 1000 / CLK_NS;       // 8000
  localparam int C_REFI = T_REFI_NS / CLK_NS;               // 624
  localparam int CNT_W = 14;
  // =====================================================================
  // controller states, one-hot
  typedef enum logic [8:0] {
    ST_PWR  = 9'h001,  // power-up pause
    ST_IDLE = 9'h002,  // waiting for work
    ST_RAS  = 9'h004,  // row strobe low, before column
    ST_CAS  = 9'h008,  // column strobe low, access
    ST_WLAT = 9'h010,  // row held low to its minimum time
    ST_PRE  = 9'h020,  // precharge, strobes high
    ST_CBR1 = 9'h040,  // refresh: column low before row
    ST_CBR2 = 9'h080,  // refresh: row low
    ST_OFF  = 9'h100   // wait for memory outputs to float
  } dmc_state_t;
  // =====================================================================
  // whole controller state
  typedef struct packed {
    dmc_state_t st;
    logic [CNT_W-1:0] tmr;       // phase timer
    logic [CNT_W-1:0] refi;      // refresh interval timer
    logic ref_pend;              // refresh owed
    logic [3:0] init_left;       // remaining init cycles
    logic is_wr;                 // current access writes
    logic [ADDR_W-1:0] col;      // latched column
    logic [DATA_W-1:0] wdat;     // latched write data
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic oe_n;
    logic [ADDR_W-1:0] addr;
    logic dq_oe;
    logic [DATA_W-1:0] dq_o;
    logic ready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic busy;
    logic [2:0][DATA_W-1:0] dq_sync; // three-stage input sync
  } dmc_regs_t;
endpackage : dmc_pkg

// ---- dmc_ctrl.sv ----
// host controller that drives a 256K x 4 page-mode dynamic memory through its pins
`timescale 1ns/1ps
module dmc_ctrl #(
  parameter int INIT_WAIT = dmc_pkg::C_INIT,   // power-up pause in cycles
  parameter int REF_INTERVAL = dmc_pkg::C_REFI // refresh spacing in cycles
) (
  input wire logic core_clk,                            // 40 MHz clock
  input wire logic rst,                                 // sync reset, high
  input wire logic req_valid,                           // user request
  input wire logic req_write,                           // 1 write, 0 read
  input wire logic [17:0] req_addr,                     // row[17:9], col[8:0]
  input wire logic [dmc_pkg::DATA_W-1:0] req_wdata,     // write data
  output logic req_ready,                               // request taken pulse
  output logic rd_valid,                                // read data pulse
  output logic [dmc_pkg::DATA_W-1:0] rd_data,           // read data
  output logic init_busy,                               // power-up in progress
  output logic ras_n,                                   // row strobe, low active
  output logic cas_n,                                   // column strobe, low active
  output logic we_n,                                    // write strobe, low active
  output logic oe_n,                                    // output enable, low active
  output logic [dmc_pkg::ADDR_W-1:0] multiplexed_address_bus, // row/column address
  input wire logic [dmc_pkg::DATA_W-1:0] data_io_lines_i,     // data from memory
  output logic [dmc_pkg::DATA_W-1:0] data_io_lines_o,         // data to memory
  output logic data_io_lines_oe                               // high while driving
);
  // =====================================================================
  // state
  dmc_pkg::dmc_regs_t r_ff;
  dmc_pkg::dmc_regs_t nxt_r;
  // cycle budget at 40 MHz with the default constants:
  //   access: row low 2 cycles before column, column low 2 (write) or 6 (read)
  //   close: strobes high, 2 cycles for the memory to float, 2 more precharge
  //   refresh: column low 1 cycle, row low 4, precharge 4
  // a timer value of N means N+1 cycles in the phase, hence ld() takes one off
  localparam logic [dmc_pkg::CNT_W-1:0] ONE = 14'h0001;

  // timer loader, used in many places
  function automatic logic [dmc_pkg::CNT_W-1:0] ld(input int c);
    ld = dmc_pkg::CNT_W'(c - 1);
  endfunction : ld

  // =====================================================================
  // next-state logic
  always_comb begin
    nxt_r = r_ff;
    nxt_r.ready = 1'b0;
    nxt_r.rvalid = 1'b0;
    // sync: a pin change counts once stages 2 and 3 agree
    nxt_r.dq_sync = {r_ff.dq_sync[1:0], data_io_lines_i};
    if (r_ff.tmr != '0) begin
      nxt_r.tmr = r_ff.tmr - ONE;
    end
    // refresh interval runs in every state but the pause so no row slot is ever lost
    // counting from zero after the pause puts the first owed refresh
    // right behind the wake-up cycles
    if (r_ff.st != dmc_pkg::ST_PWR) begin
      if (r_ff.refi == '0) begin
        nxt_r.refi = ld(REF_INTERVAL);
        nxt_r.ref_pend = 1'b1;
      end else begin
        nxt_r.refi = r_ff.refi - ONE;
      end
    end
    case (r_ff.st)
      // power-up pause: every strobe stays high and requests are refused
      dmc_pkg::ST_PWR: begin
        // all strobes high during the pause
        if (r_ff.tmr == '0) begin
          nxt_r.st = dmc_pkg::ST_IDLE;
          nxt_r.init_left = 4'(dmc_pkg::INIT_CYCLES);
        end
      end
      // idle: owed refresh and wake-up cycles go first, then a user request;
      // the request is taken here and req_ready pulses on the next cycle
      dmc_pkg::ST_IDLE: begin
        if (r_ff.tmr == '0) begin
          // refresh and wake-up cycles win over user work
          // only the counter form is issued; row-only and hidden refresh never run
          if (r_ff.ref_pend || r_ff.init_left != 4'h0) begin
            nxt_r.cas_n = 1'b0; // column falls first
            nxt_r.we_n = 1'b1;
            nxt_r.oe_n = 1'b1;
            nxt_r.tmr = ld(dmc_pkg::C_CSR);
            nxt_r.st = dmc_pkg::ST_CBR1;
            if (r_ff.init_left != 4'h0) begin
              nxt_r.init_left = r_ff.init_left - 4'h1;
            end else begin
              // an interval that ends in this very cycle keeps the flag set
              nxt_r.ref_pend = (r_ff.refi == '0);
            end
          end else if (req_valid) begin
            nxt_r.ready = 1'b1;
            nxt_r.is_wr = req_write;
            nxt_r.col = req_addr[8:0];
            nxt_r.wdat = req_wdata;
            nxt_r.addr = req_addr[17:9];  // row first
            nxt_r.ras_n = 1'b0;           // opens and refreshes row
            nxt_r.we_n = ~req_write;      // early write only, never delayed
            nxt_r.oe_n = req_write;       // float memory on write
            nxt_r.tmr = ld(dmc_pkg::C_RCD);
            nxt_r.st = dmc_pkg::ST_RAS;
          end
        end
      end
      // row open: column address goes out one cycle ahead of its strobe,
      // so the address access time runs before the column strobe falls
      dmc_pkg::ST_RAS: begin
        nxt_r.addr = r_ff.col; // column flows through early
        if (r_ff.tmr == '0) begin
          // write data goes out with the column fall; setup is zero and the
          // hold is kept by driving until the strobes rise
          if (r_ff.is_wr) begin
            nxt_r.dq_o = r_ff.wdat;  // latched on column fall
            nxt_r.dq_oe = 1'b1;
          end
          nxt_r.cas_n = 1'b0;
          // read waits column access plus three sync stages
          nxt_r.tmr = r_ff.is_wr ? ld(dmc_pkg::C_CAS) : ld(dmc_pkg::C_CAC + 3);
          nxt_r.st = dmc_pkg::ST_CAS;
        end
      end
      // column low: a write is taken by the memory on this fall; a read waits
      // the access time plus the input synchroniser, then samples
      // limitation: a read whose lines never settle holds the row open
      dmc_pkg::ST_CAS: begin
        if (r_ff.tmr == '0) begin
          if (!r_ff.is_wr && r_ff.dq_sync[1] == r_ff.dq_sync[2]) begin
            nxt_r.rdata = r_ff.dq_sync[2]; // taken as is
            nxt_r.rvalid = 1'b1;
          end
          if (r_ff.is_wr || r_ff.dq_sync[1] == r_ff.dq_sync[2]) begin
            nxt_r.st = dmc_pkg::ST_WLAT;
            nxt_r.tmr = ld(dmc_pkg::C_RAS > dmc_pkg::C_RCD + dmc_pkg::C_CAS
                           ? dmc_pkg::C_RAS - dmc_pkg::C_RCD - dmc_pkg::C_CAS : 1);
          end
        end
      end
      // keep the row low for its minimum time, then close both strobes;
      // oe_n and the data drive drop on the same edge
      dmc_pkg::ST_WLAT: begin
        if (r_ff.tmr == '0) begin
          nxt_r.ras_n = 1'b1;
          nxt_r.cas_n = 1'b1;  // memory floats after rise
          nxt_r.oe_n = 1'b1;
          nxt_r.we_n = 1'b1;
          nxt_r.dq_oe = 1'b0;
          nxt_r.tmr = ld(dmc_pkg::C_OFF);
          nxt_r.st = dmc_pkg::ST_OFF;
        end
      end
      // output disable time: nothing may start while the memory still drives the lines
      dmc_pkg::ST_OFF: begin
        if (r_ff.tmr == '0) begin
          nxt_r.tmr = ld(dmc_pkg::C_RP - dmc_pkg::C_OFF);
          nxt_r.st = dmc_pkg::ST_PRE;
        end
      end
      // refresh, column already low: drop the row strobe so the memory
      // refreshes the row its own counter points at
      dmc_pkg::ST_CBR1: begin
        if (r_ff.tmr == '0) begin
          nxt_r.ras_n = 1'b0; // internal counter, address ignored
          nxt_r.tmr = ld(dmc_pkg::C_RAS > dmc_pkg::C_CHR ? dmc_pkg::C_RAS : dmc_pkg::C_CHR);
          nxt_r.st = dmc_pkg::ST_CBR2;
        end
      end
      // keep both strobes low for the row-low minimum, then release together
      dmc_pkg::ST_CBR2: begin
        if (r_ff.tmr == '0) begin
          nxt_r.ras_n = 1'b1;
          // column rises between refreshes; the held-low chain is not used
          nxt_r.cas_n = 1'b1;
          nxt_r.tmr = ld(dmc_pkg::C_RP);
          nxt_r.st = dmc_pkg::ST_PRE;
        end
      end
      // precharge with both strobes high before anything new may start
      dmc_pkg::ST_PRE: begin
        if (r_ff.tmr == '0) begin
          nxt_r.st = dmc_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_r.st = dmc_pkg::ST_IDLE;
      end
    endcase
    // busy covers the pause and the wake-up refreshes; it drops as the last
    // one starts, and requests still wait for idle
    nxt_r.busy = (nxt_r.st == dmc_pkg::ST_PWR) || (nxt_r.init_left != 4'h0);
  end

  // =====================================================================
  // registers; reset holds strobes high and starts the power-up pause
  // the reset branch loads constants only; the pause length is a parameter
  always_ff @(posedge core_clk) begin
    if (rst) begin
      r_ff <= '0;
      r_ff.st <= dmc_pkg::ST_PWR;
      r_ff.tmr <= ld(INIT_WAIT);
      r_ff.ras_n <= 1'b1;
      r_ff.cas_n <= 1'b1;
      r_ff.we_n <= 1'b1;
      r_ff.oe_n <= 1'b1;
      r_ff.busy <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // outputs straight from the state register
  assign req_ready = r_ff.ready;
  assign rd_valid = r_ff.rvalid;
  assign rd_data = r_ff.rdata;
  assign init_busy = r_ff.busy;
  assign ras_n = r_ff.ras_n;
  assign cas_n = r_ff.cas_n;
  assign we_n = r_ff.we_n;
  assign oe_n = r_ff.oe_n;
  assign multiplexed_address_bus = r_ff.addr;
  assign data_io_lines_o = r_ff.dq_o;
  assign data_io_lines_oe = r_ff.dq_oe;
endmodule : dmc_ctrl

// ---- dmc_ctrl_properties.sv ----
// checker of the controller's pin sequencing
`timescale 1ns/1ps
module dmc_ctrl_props (
  input wire logic core_clk, // clock
  input wire logic rst, // sync reset
  input wire logic req_ready, // taken pulse
  input wire logic rd_valid, // read pulse
  input wire logic init_busy, // power-up busy
  input wire logic ras_n, // row strobe
  input wire logic cas_n, // column strobe
  input wire logic we_n, // write strobe
  input wire logic oe_n, // output enable
  input wire logic [dmc_pkg::ADDR_W-1:0] multiplexed_address_bus, // address
  input wire logic data_io_lines_oe // data drive enable
);
  // ==================================================================
  // sequences
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_cbr_start;
    $fell(cas_n) && ras_n;
  endsequence
  sequence s_row_open;
    $fell(ras_n) && cas_n;
  endsequence
  sequence s_col_latch;
    $fell(cas_n) && $stable(multiplexed_address_bus);
  endsequence
  // ==================================================================
  // properties
  a_cbr_row_follows: assert property (s_cbr_start |-> (!cas_n) throughout (##[1:2] !ras_n))
    else $error("refresh row strobe late");
  a_cbr_col_hold: assert property ($fell(ras_n) && !cas_n |=> !cas_n)
    else $error("column strobe not held in refresh");
  a_col_after_row: assert property (s_row_open |-> ##[1:4] s_col_latch)
    else $error("column not latched after row");
  a_early_write: assert property ($fell(cas_n) && !ras_n && !we_n |->
    oe_n && data_io_lines_oe && !$past(we_n))
    else $error("write not early");
  a_no_fight: assert property (data_io_lines_oe |-> oe_n)
    else $error("drive while memory enabled");
  a_init_gate: assert property (init_busy |-> !req_ready)
    else $error("request taken during power-up");
  a_read_wait: assert property (rd_valid |-> !$past(cas_n, 4) && $past(we_n, 4))
    else $error("read sampled too early");
  a_reset_quiet: assert property (disable iff (1'b0)
    rst |=> ras_n && cas_n && init_busy && !req_ready)
    else $error("strobes active after reset");
endmodule : dmc_ctrl_props
bind dmc_ctrl dmc_ctrl_props u_dmc_ctrl_props (.core_clk(core_clk), .rst(rst),
  .req_ready(req_ready), .rd_valid(rd_valid), .init_busy(init_busy), .ras_n(ras_n),
  .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n), .multiplexed_address_bus(multiplexed_address_bus),
  .data_io_lines_oe(data_io_lines_oe));

// ---- dmc_mem_model.sv ----
// behavioural model of the 256K x 4 page-mode dynamic memory
`timescale 1ns/1ps
module dmc_mem_model (
  input wire logic ras_n, // row strobe
  input wire logic cas_n, // column strobe
  input wire logic we_n, // write strobe
  input wire logic oe_n, // output enable
  input wire logic [8:0] multiplexed_address_bus, // row then column
  input wire logic [3:0] dq_in, // resolved data lines
  output logic [3:0] dq_q, // memory side of the lines
  output logic [15:0] cbr_cnt // refreshes by internal counter
);
  // ==================================================================
  // storage
  logic [3:0] mem [int]; // sparse cells
  logic [8:0] row = 9'h000; // open row
  logic [8:0] col = 9'h000; // latched column
  logic [8:0] ref_row = 9'h000; // internal refresh row
  logic [3:0] rd = 4'h5; // word at the open location
  logic ok = 1'b0; // access time elapsed
  initial cbr_cnt = 16'h0000;
  // row fall: counter refresh when column already low, else open row
  always @(negedge ras_n) begin
    #1;
    if (!cas_n) begin
      ref_row = ref_row + 9'h001;
      cbr_cnt = cbr_cnt + 16'h0001;
    end else begin
      row = multiplexed_address_bus;
    end
  end
  // column fall latches column, early write stores data
  always @(negedge cas_n) begin
    #1;
    if (!ras_n) begin
      col = multiplexed_address_bus;
      if (!we_n) mem[{row, col}] = dq_in;
      rd = mem.exists({row, col}) ? mem[{row, col}] : 4'h5;
      ok <= #24 1'b1;
    end
  end
  // no page mode here: access restarts at every column fall
  always @(posedge cas_n) ok = 1'b0;
  // delayed write latches on write fall
  always @(negedge we_n) if (!cas_n && !ras_n) mem[{row, col}] = dq_in;
  // drive only in read with column and enable low; floating shows inverse
  always_comb begin
    if (!cas_n && !oe_n && we_n && ok) dq_q = rd;
    else dq_q = ~rd;
  end
endmodule : dmc_mem_model

// ---- dmc_ctrl_tb.sv ----
// self-checking testbench of the memory host controller
`timescale 1ns/1ps
module dmc_ctrl_tb;
  logic core_clk = 1'b0; // 40 MHz
  logic rst = 1'b1; // sync reset
  logic req_valid = 1'b0; // request
  logic req_write = 1'b0; // direction
  logic [17:0] req_addr = 18'h00000; // location
  logic [3:0] req_wdata = 4'h0; // write word
  logic req_ready, rd_valid, init_busy, ras_n, cas_n, we_n, oe_n, dq_oe;
  logic [3:0] rd_data, dq_o, mem_q, dq_bus;
  logic [8:0] abus; // multiplexed address
  logic [15:0] cbr_cnt; // model refresh count
  logic tk_busy; // busy flag at the take edge
  int n_errors = 0;
  int checks_done = 0;
  // resolved data lines: controller drive wins, else memory side
  assign dq_bus = dq_oe ? dq_o : mem_q;
  dmc_ctrl #(.INIT_WAIT(20), .REF_INTERVAL(60)) u_dmc_ctrl (.core_clk(core_clk), .rst(rst),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .init_busy(init_busy), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n),
    .multiplexed_address_bus(abus), .data_io_lines_i(dq_bus), .data_io_lines_o(dq_o),
    .data_io_lines_oe(dq_oe));
  dmc_mem_model u_dmc_mem_model (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n),
    .multiplexed_address_bus(abus), .dq_in(dq_bus), .dq_q(mem_q), .cbr_cnt(cbr_cnt));
  initial forever #12.5 core_clk = ~core_clk;
  // ==================================================================
  // shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    if (n_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  // one access held until taken; a read also waits for its data pulse
  task automatic xfer(input logic w, input logic [17:0] a, input logic [3:0] d,
                      output logic [3:0] q);
    int i;
    @(posedge core_clk);
    #2 {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, a, d};
    i = 0;
    // look 1 ns after each edge, once the registered pulse has settled
    do begin @(posedge core_clk); #1; i++; end while (req_ready !== 1'b1 && i < 600);
    check({15'h0, req_ready}, 16'h0001);
    tk_busy = init_busy;
    #1 req_valid = 1'b0;
    q = 4'hX;
    i = 0;
    while (!w && rd_valid !== 1'b1 && i < 40) begin @(posedge core_clk); #1; i++; end
    if (!w) check({15'h0, rd_valid}, 16'h0001);
    if (!w) q = rd_data;
  endtask : xfer
  // ==================================================================
  // scenarios
  task automatic t_init();
    logic [3:0] q;
    xfer(1'b1, 18'h2AA55, 4'hC, q); // held from reset release
    check({15'h0, tk_busy}, 16'h0000);
    check({15'h0, cbr_cnt >= 16'h0008}, 16'h0001);
  endtask : t_init
  task automatic t_data();
    logic [17:0] ad [4] = '{18'h00000, 18'h3FFFF, 18'h3FE00, 18'h155AA};
    logic [3:0] dv [4] = '{4'hF, 4'h0, 4'h9, 4'h6};
    logic [3:0] q;
    foreach (ad[k]) xfer(1'b1, ad[k], dv[k], q);
    foreach (ad[k]) begin
      xfer(1'b0, ad[k], 4'h0, q);
      check({12'h0, q}, {12'h0, dv[k]});
    end
  endtask : t_data
  task automatic t_refresh();
    logic [15:0] c0;
    logic [3:0] q;
    c0 = cbr_cnt;
    repeat (180) @(posedge core_clk);
    check({15'h0, (cbr_cnt - c0) inside {[2:4]}}, 16'h0001);
    xfer(1'b0, 18'h2AA55, 4'h0, q);
    check({12'h0, q}, 16'h000C);
  endtask : t_refresh
  // ==================================================================
  // main sequence and watchdog
  initial begin
    repeat (6) @(posedge core_clk);
    #2 rst = 1'b0;
    t_init();
    t_data();
    t_refresh();
    summarize();
  end
  initial begin
    #(25 * 6000);
    n_errors++;
    summarize();
  end
endmodule : dmc_ctrl_tb
